// ==== ldc_pkg.sv ====
// Shared constants and types of the listen duty-cycle and auto-mode sequencer
package ldc_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] LDC_OFS_OPMODE = 8'h00; // Operating mode register
    localparam logic [7:0] LDC_OFS_LISTEN = 8'h04; // Listen configuration
    localparam logic [7:0] LDC_OFS_OSC = 8'h08; // Oscillator control
    localparam logic [7:0] LDC_OFS_AUTO = 8'h0C; // Auto transition setup
    localparam logic [7:0] LDC_OFS_STATUS = 8'h10; // Read-only status

    // ****************************************
    // Field positions
    // ****************************************
    localparam int LDC_OP_MODE_LSB = 0; // Mode field [2:0]
    localparam int LDC_OP_CANCEL_BIT = 5; // listen_cancel
    localparam int LDC_OP_ENABLE_BIT = 6; // listen_enable
    localparam int LDC_LI_END_LSB = 1; // end_of_cycle_action [2:1]
    localparam int LDC_LI_CRIT_BIT = 3; // accept_criterion
    localparam int LDC_LI_RXSTEP_LSB = 4; // Receive phase_step_select [5:4]
    localparam int LDC_LI_IDSTEP_LSB = 6; // Idle phase_step_select [7:6]
    localparam int LDC_LI_IDMUL_LSB = 8; // Idle phase_multiplier [15:8]
    localparam int LDC_LI_RXMUL_LSB = 16; // Receive phase_multiplier [23:16]
    localparam int LDC_OSC_BEGIN_BIT = 0; // rc_trim_begin, write one
    localparam int LDC_OSC_DONE_BIT = 1; // rc_trim_finished, read only
    localparam int LDC_AU_ENTRY_LSB = 0; // transit_entry_event [2:0]
    localparam int LDC_AU_LEAVE_LSB = 3; // transit_leave_event [5:3]
    localparam int LDC_AU_TRANSIT_LSB = 8; // transit_mode [10:8]

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [31:0] LDC_RST_OPMODE = 32'h0000_0001; // Standby
    localparam logic [31:0] LDC_RST_LISTEN = 32'h0001_F592; // Mult 245 / 1
    localparam logic [31:0] LDC_RST_AUTO = 32'h0000_0000; // Auto modes off

    // ****************************************
    // Radio modes, actions, events
    // ****************************************
    localparam logic [2:0] LDC_MODE_SLEEP = 3'h0;
    localparam logic [2:0] LDC_MODE_STDBY = 3'h1;
    localparam logic [2:0] LDC_MODE_FS = 3'h2;
    localparam logic [2:0] LDC_MODE_TX = 3'h3;
    localparam logic [2:0] LDC_MODE_RX = 3'h4;
    localparam logic [1:0] LDC_END_STAY = 2'h0; // Stay in receive
    localparam logic [1:0] LDC_END_TO_MODE = 2'h1; // Then go to mode field
    localparam logic [1:0] LDC_END_RESUME = 2'h2; // Then resume idle
    localparam logic [2:0] LDC_EV_OFF = 3'h0; // Condition disabled
    localparam logic [2:0] LDC_EV_LEVEL = 3'h1; // buffer_threshold_hit
    localparam logic [2:0] LDC_EV_SENT = 3'h2; // frame_transmitted
    localparam logic [2:0] LDC_EV_CRC = 3'h3; // checksum_good
    localparam logic [2:0] LDC_EV_EMPTIED = 3'h4; // Falling buffer_has_data
    localparam logic [2:0] LDC_EV_PAYLOAD = 3'h5; // payload_complete

    // ****************************************
    // Timing: RC tick is the finest step
    // ****************************************
    localparam int LDC_CLK_HZ = 20_000_000; // hclk rate
    localparam int LDC_STEP_FINE_US = 64; // Code 01 step
    localparam logic [12:0] LDC_TICKS_FINE = 13'h0001; // 64 us
    localparam logic [12:0] LDC_TICKS_MID = 13'h0040; // 64 x 64 us = 4.1 ms
    localparam logic [12:0] LDC_TICKS_COARSE = 13'h1000; // 4096 x 64 us = 262 ms
    localparam int LDC_TRIM_US = 100; // RC calibration duration
    localparam int LDC_TRIM_CYC = (LDC_TRIM_US * (LDC_CLK_HZ / 1_000_000)); // Cycles

    // Listen sequencer states
    typedef enum logic [2:0] {
        LDC_L_OFF,
        LDC_L_IDLE,
        LDC_L_RX,
        LDC_L_HOLD,
        LDC_L_WAIT
    } ldc_lstate_t;

endpackage : ldc_pkg

// ==== ldc_phase_timer.sv ====
// Phase duration timer counting RC ticks: multiplier times step
`timescale 1ns/1ns
module ldc_phase_timer (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic load, // Restart timing a phase
    input wire logic [1:0] step_sel, // phase_step_select code
    input wire logic [7:0] mult, // phase_multiplier
    input wire logic rc_tick, // One pulse per RC tick
    output logic expired // One-cycle pulse at phase end
);
    import ldc_pkg::*;

    logic [12:0] step_cnt_r; // Ticks left in current step
    logic [7:0] mult_cnt_r; // Steps left in phase
    logic run_r; // Phase being timed
    logic [12:0] step_len; // Ticks per step

    // ****************************************
    // Step length decode
    // ****************************************
    // Reserved code 00 falls back to the finest step
    assign step_len = (step_sel == 2'h3) ? LDC_TICKS_COARSE :
                      (step_sel == 2'h2) ? LDC_TICKS_MID : LDC_TICKS_FINE;

    // ****************************************
    // Counters
    // ****************************************
    // Duration = mult x step, all on RC ticks, never hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_cnt_r <= 13'h0000;
            mult_cnt_r <= 8'h00;
            run_r <= 1'b0;
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (load) begin // Reload at phase entry
                step_cnt_r <= step_len;
                mult_cnt_r <= (mult == 8'h00) ? 8'h01 : mult; // Zero treated as 1
                run_r <= 1'b1;
            end else if (run_r && rc_tick) begin
                if (step_cnt_r == 13'h0001) begin
                    step_cnt_r <= step_len;
                    mult_cnt_r <= mult_cnt_r - 8'h01;
                    if (mult_cnt_r == 8'h01) begin // Last step done
                        run_r <= 1'b0;
                        expired <= 1'b1;
                    end
                end else begin
                    step_cnt_r <= step_cnt_r - 13'h0001;
                end
            end
        end
    end

endmodule : ldc_phase_timer

// ==== ldc_sequencer.sv ====
// Listen duty-cycle and auto-mode sequencer with AHB-Lite register slave
//
// Operation
// - Phase time is multiplier times step
// - Step codes give 64us, 4.1ms, 262ms
// - Receive window includes receiver wake-up
// - Listen starts on enable set in Standby
// - Idle phase keeps receiver and synthesizer off
// - No signal: receiver off, await next idle
// - Criterion 0 power only, 1 adds sync
// - End 00: stay receive, sequencing stops
// - End 01: wait end, go mode field
// - End 10: wait end, resume idle, clear FIFO
// - All phase times come from RC ticks
// - RC calibration runs itself after reset
// - Trim begin recalibrates, sets finished flag
// - Auto mode moves base to transit and back
// - Leave goes to current mode field
// - Auto events include edge of buffer_has_data
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module ldc_sequencer (
    input wire logic hclk, // System clock, 20 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic ce, // Clock enable, freezes all state
    input wire logic hsel, // AHB slave select
    input wire logic [7:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic rc_tick_pin, // RC oscillator tick, async
    input wire logic power_detect_level, // Input power above threshold
    input wire logic sync_addr_hit, // Sync or address matched
    input wire logic payload_complete, // Payload ready event
    input wire logic rx_timeout, // Receive timeout event
    input wire logic buffer_threshold_hit, // FIFO level reached
    input wire logic frame_transmitted, // Packet sent
    input wire logic checksum_good, // CRC OK
    input wire logic buffer_has_data, // FIFO not empty level
    output logic [2:0] radio_mode, // Mode applied to radio
    output logic receiver_on, // Receiver and synth powered
    output logic fifo_flush, // One-cycle FIFO clear pulse
    output logic rc_trim_active // RC calibration running
);
    import ldc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    localparam int TRIM_W = $clog2(LDC_TRIM_CYC + 1); // Trim counter width
    localparam logic [TRIM_W-1:0] TRIM_LOAD = TRIM_W'(LDC_TRIM_CYC); // Trim length

    logic [31:0] opmode_r; // Operating mode register
    logic [31:0] listen_r; // Listen configuration
    logic [31:0] auto_r; // Auto transition setup
    logic trim_done_r; // rc_trim_finished flag
    logic [TRIM_W-1:0] trim_cnt_r; // Calibration cycles left
    logic [7:0] dp_addr_r; // Data-phase address
    logic dp_wr_r; // Data-phase write pending
    logic [2:0] tick_sync_r; // RC tick synchroniser and edge
    ldc_lstate_t lstate_r; // Listen state
    logic flush_pend_r; // Clear FIFO at next wake-up
    logic in_transit_r; // Auto mode in transit
    logic buf_data_d_r; // Delayed buffer_has_data

    // ****************************************
    // Bus decode
    // ****************************************
    wire addr_ph = hsel && htrans[1] && hready; // Address phase taken
    wire wr_op = dp_wr_r && (dp_addr_r == LDC_OFS_OPMODE); // Opmode write
    wire wr_li = dp_wr_r && (dp_addr_r == LDC_OFS_LISTEN); // Listen write
    wire wr_osc = dp_wr_r && (dp_addr_r == LDC_OFS_OSC); // Osc write
    wire wr_au = dp_wr_r && (dp_addr_r == LDC_OFS_AUTO); // Auto write
    wire [2:0] mode_field = opmode_r[LDC_OP_MODE_LSB +: 3]; // Programmed mode
    wire [2:0] new_mode = hwdata[LDC_OP_MODE_LSB +: 3]; // Mode being written
    wire new_enable = hwdata[LDC_OP_ENABLE_BIT]; // Enable being written
    wire new_cancel = hwdata[LDC_OP_CANCEL_BIT]; // Cancel being written

    // ****************************************
    // Listen event decode
    // ****************************************
    wire rc_tick = tick_sync_r[1] && !tick_sync_r[2]; // Rising RC tick
    wire [1:0] end_act = listen_r[LDC_LI_END_LSB +: 2]; // end_of_cycle_action
    wire criterion = listen_r[LDC_LI_CRIT_BIT]; // accept_criterion
    // Criterion 1 also needs a sync-address match
    wire accepted = power_detect_level && (!criterion || sync_addr_hit);
    wire rx_end_ev = payload_complete || rx_timeout; // Reception finished
    // Start only on a fresh enable while in Standby
    wire listen_start = wr_op && new_enable && !new_cancel && !opmode_r[LDC_OP_ENABLE_BIT]
                        && (mode_field == LDC_MODE_STDBY) && (lstate_r == LDC_L_OFF);
    wire listen_cancel = wr_op && new_cancel;
    wire idle_exp; // Idle timer expired
    wire rx_exp; // Receive timer expired
    wire idle_load = listen_start || (lstate_r == LDC_L_RX && rx_exp && !accepted)
                     || (lstate_r == LDC_L_WAIT && rx_end_ev && end_act == LDC_END_RESUME);
    wire rx_load = (lstate_r == LDC_L_IDLE) && idle_exp; // Wake-up starts the window

    // ****************************************
    // Auto-mode event decode
    // ****************************************
    wire [2:0] entry_sel = auto_r[LDC_AU_ENTRY_LSB +: 3]; // transit_entry_event
    wire [2:0] leave_sel = auto_r[LDC_AU_LEAVE_LSB +: 3]; // transit_leave_event
    wire [2:0] transit_mode = auto_r[LDC_AU_TRANSIT_LSB +: 3]; // Intermediate mode
    // Both conditions must be set; one alone leaves auto mode inert
    wire auto_on = (entry_sel != LDC_EV_OFF) && (leave_sel != LDC_EV_OFF);
    wire emptied = buf_data_d_r && !buffer_has_data; // Edge, not level
    wire entry_hit = ev_hit(entry_sel); // Entry condition seen
    wire leave_hit = ev_hit(leave_sel); // Leave condition seen

    // Selects one of the automatic-mode events
    function automatic logic ev_hit(input logic [2:0] sel);
        case (sel)
            LDC_EV_LEVEL: ev_hit = buffer_threshold_hit;
            LDC_EV_SENT: ev_hit = frame_transmitted;
            LDC_EV_CRC: ev_hit = checksum_good;
            LDC_EV_EMPTIED: ev_hit = emptied;
            LDC_EV_PAYLOAD: ev_hit = payload_complete;
            default: ev_hit = 1'b0;
        endcase
    endfunction : ev_hit

    // ****************************************
    // Read mux
    // ****************************************
    wire [31:0] status_word = {23'h0, in_transit_r, 2'h0, lstate_r, radio_mode};
    wire [31:0] rd_word = (haddr == LDC_OFS_OPMODE) ? opmode_r :
                          (haddr == LDC_OFS_LISTEN) ? listen_r :
                          (haddr == LDC_OFS_OSC) ? {30'h0, trim_done_r, 1'b0} :
                          (haddr == LDC_OFS_AUTO) ? auto_r :
                          (haddr == LDC_OFS_STATUS) ? status_word : 32'h0000_0000;

    // ****************************************
    // Radio mode selection
    // ****************************************
    // Listen owns the radio while active; otherwise auto mode or mode field
    wire listen_rx = lstate_r inside {LDC_L_RX, LDC_L_HOLD, LDC_L_WAIT};
    wire [2:0] mode_nxt = listen_rx ? LDC_MODE_RX :
                          (lstate_r == LDC_L_IDLE) ? LDC_MODE_STDBY :
                          in_transit_r ? transit_mode : mode_field;

    // ****************************************
    // Phase timers
    // ****************************************
    ldc_phase_timer u_idle_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .load(idle_load),
        .step_sel(listen_r[LDC_LI_IDSTEP_LSB +: 2]),
        .mult(listen_r[LDC_LI_IDMUL_LSB +: 8]),
        .rc_tick(rc_tick),
        .expired(idle_exp)
    );

    ldc_phase_timer u_rx_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .load(rx_load),
        .step_sel(listen_r[LDC_LI_RXSTEP_LSB +: 2]),
        .mult(listen_r[LDC_LI_RXMUL_LSB +: 8]),
        .rc_tick(rc_tick),
        .expired(rx_exp)
    );

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    // Read data registered in the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_addr_r <= 8'h00;
            dp_wr_r <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            dp_wr_r <= addr_ph && hwrite;
            dp_addr_r <= haddr;
            if (addr_ph && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    // Cancel clears enable whatever was written with it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opmode_r <= LDC_RST_OPMODE;
            listen_r <= LDC_RST_LISTEN;
            auto_r <= LDC_RST_AUTO;
        end else if (ce) begin
            if (wr_op) begin // Mode field is read live on leave
                opmode_r <= {25'h0, hwdata[LDC_OP_ENABLE_BIT] & ~new_cancel,
                             new_cancel, 2'h0, new_mode};
            end
            if (wr_li) begin
                listen_r <= {8'h00, hwdata[23:8], hwdata[7:1], 1'b0};
            end
            if (wr_au) begin
                auto_r <= {21'h0, hwdata[10:8], 2'h0, hwdata[5:0]};
            end
        end
    end

    // ****************************************
    // RC tick synchroniser
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_sync_r <= 3'h0;
        end else if (ce) begin
            tick_sync_r <= {tick_sync_r[1:0], rc_tick_pin};
        end
    end

    // ****************************************
    // RC calibration
    // ****************************************
    // Starts by itself out of reset; a later begin restarts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_cnt_r <= TRIM_LOAD; // Power-up calibration
            trim_done_r <= 1'b0;
        end else if (ce) begin
            if (wr_osc && hwdata[LDC_OSC_BEGIN_BIT]) begin
                trim_cnt_r <= TRIM_LOAD;
                trim_done_r <= 1'b0;
            end else if (trim_cnt_r != '0) begin
                trim_cnt_r <= trim_cnt_r - 1'b1;
                if (trim_cnt_r == TRIM_W'(1)) begin
                    trim_done_r <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Listen sequencer
    // ****************************************
    // Cancel beats every other transition so no phase survives it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lstate_r <= LDC_L_OFF;
            flush_pend_r <= 1'b0;
        end else if (ce) begin
            if (listen_cancel) begin
                lstate_r <= LDC_L_OFF;
                flush_pend_r <= 1'b0;
            end else begin
                case (lstate_r)
                    LDC_L_OFF: begin
                        if (listen_start) begin
                            lstate_r <= LDC_L_IDLE;
                        end
                    end
                    LDC_L_IDLE: begin // Only RC ticks run here
                        if (idle_exp) begin
                            lstate_r <= LDC_L_RX;
                            flush_pend_r <= 1'b0;
                        end
                    end
                    LDC_L_RX: begin
                        if (accepted) begin
                            lstate_r <= (end_act == LDC_END_STAY) ? LDC_L_HOLD : LDC_L_WAIT;
                        end else if (rx_exp) begin
                            lstate_r <= LDC_L_IDLE;
                        end
                    end
                    LDC_L_HOLD: begin
                        lstate_r <= LDC_L_HOLD; // Host must clear listen
                    end
                    LDC_L_WAIT: begin
                        if (rx_end_ev && end_act == LDC_END_RESUME) begin
                            lstate_r <= LDC_L_IDLE;
                            flush_pend_r <= 1'b1;
                        end else if (rx_end_ev) begin
                            lstate_r <= LDC_L_OFF; // Falls to mode field
                        end
                    end
                    default: lstate_r <= LDC_L_OFF;
                endcase
            end
        end
    end

    // ****************************************
    // Auto-mode sequencer
    // ****************************************
    // Only acts while listen is off, so the two never fight for the radio
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_transit_r <= 1'b0;
            buf_data_d_r <= 1'b0;
        end else if (ce) begin
            buf_data_d_r <= buffer_has_data;
            if (!auto_on || lstate_r != LDC_L_OFF) begin
                in_transit_r <= 1'b0;
            end else if (!in_transit_r && entry_hit) begin
                in_transit_r <= 1'b1;
            end else if (in_transit_r && leave_hit) begin
                in_transit_r <= 1'b0; // Back to mode field
            end
        end
    end

    // ****************************************
    // Radio outputs
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            radio_mode <= LDC_MODE_STDBY;
            receiver_on <= 1'b0;
            fifo_flush <= 1'b0;
            rc_trim_active <= 1'b0;
        end else if (ce) begin
            radio_mode <= mode_nxt;
            receiver_on <= (mode_nxt == LDC_MODE_RX); // Off in idle
            fifo_flush <= rx_load && flush_pend_r;
            rc_trim_active <= (trim_cnt_r != '0);
        end
    end

endmodule : ldc_sequencer

// ==== ldc_sequencer_checker.sv ====
// Port assertions for the listen sequencer
`timescale 1ns/1ns
module ldc_sequencer_checker import ldc_pkg::*; (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic ce, // Enable
    input wire logic hsel, // Select
    input wire logic [7:0] haddr, // Address
    input wire logic [1:0] htrans, // Type
    input wire logic hwrite, // Write
    input wire logic hready, // Ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic [2:0] radio_mode, // Mode
    input wire logic receiver_on, // Receiver
    input wire logic fifo_flush, // Flush
    input wire logic rc_trim_active // Trim
);
    localparam int TRIM_MAX = 2100; // Trim is 2000 cycles plus margin
    wire logic rd_req = hsel && htrans[1] && hready && ce && !hwrite; // Read taken
    int trim_n; // Trim age
    always @(posedge hclk) trim_n <= rc_trim_active ? trim_n + 1 : 0;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    rx_power_a: assert property (receiver_on |-> radio_mode == LDC_MODE_RX)
        else $error("receiver on outside rx");
    flush_pulse_a: assert property (fifo_flush |=> !fifo_flush)
        else $error("flush longer than one cycle");
    flush_wake_a: assert property (fifo_flush |-> ##[0:2] receiver_on)
        else $error("flush away from wake-up");
    trim_hold_a: assert property ($rose(rc_trim_active) |-> rc_trim_active [*8])
        else $error("trim too short");
    trim_bound_a: assert property (trim_n < TRIM_MAX)
        else $error("trim never ends");
    status_mode_a: assert property (rd_req && haddr == LDC_OFS_STATUS
        |=> hrdata[2:0] == $past(radio_mode)) else $error("status mode wrong");
    mode_legal_a: assert property (radio_mode <= LDC_MODE_RX)
        else $error("mode out of range");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    cover property ($rose(receiver_on));
    cover property (fifo_flush);
    cover property ($fell(rc_trim_active));
endmodule : ldc_sequencer_checker
bind ldc_sequencer ldc_sequencer_checker u_ldc_sequencer_checker (.hclk(hclk),
    .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .radio_mode(radio_mode), .receiver_on(receiver_on), .fifo_flush(fifo_flush),
    .rc_trim_active(rc_trim_active));

// ==== ldc_rc_model.sv ====
// Free-running RC oscillator tick source
`timescale 1ns/1ns
module ldc_rc_model (
    output logic rc_tick_pin // Tick, about 20 hclk per period
);
    // Odd half period drifts past hclk; sped up for short runs
    initial begin
        rc_tick_pin = 1'b0;
        forever #507 rc_tick_pin = ~rc_tick_pin;
    end
endmodule : ldc_rc_model

// ==== ldc_sequencer_tb.sv ====
// Self-checking bench of the listen sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module ldc_sequencer_tb;
    import ldc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, bufd = 1'b1; // Drives
    logic power = 1'b0, sync = 1'b0, payload = 1'b0, tmo = 1'b0; // Radio events
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic [2:0] evt = 3'h0, radio_mode;
    logic hready, hresp, rx_on, flush, trim, tick;
    int failures = 0, n_checks = 0, flush_cnt = 0;
    ldc_rc_model u_ldc_rc_model (.rc_tick_pin(tick));
    ldc_sequencer u_ldc_sequencer (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .rc_tick_pin(tick), .power_detect_level(power), .sync_addr_hit(sync),
        .payload_complete(payload), .rx_timeout(tmo), .buffer_threshold_hit(evt[0]),
        .frame_transmitted(evt[1]), .checksum_good(evt[2]), .buffer_has_data(bufd),
        .radio_mode(radio_mode), .receiver_on(rx_on), .fifo_flush(flush),
        .rc_trim_active(trim));
    initial begin
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) if (flush === 1'b1) flush_cnt++;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // One single transfer; waits on hready, data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin failures++; tally_and_finish(); end
    endtask : bus
    task automatic wait_rx(input logic v);
        int n;
        for (n = 0; n < 3000 && rx_on !== v; n++) @(posedge hclk);
        `CHK("receiver_on", v, rx_on)
        if (n >= 3000) tally_and_finish();
    endtask : wait_rx
    task automatic trim_wait();
        int n;
        rd = 32'h0;
        for (n = 0; n < 1500 && rd[1] !== 1'b1; n++) bus(1'b0, LDC_OFS_OSC, 32'h0);
        `CHK("trim_done", 1'b1, rd[1])
        if (n >= 1500) tally_and_finish();
    endtask : trim_wait
    task automatic pulse_end(input logic pl);
        payload <= pl;
        tmo <= !pl;
        @(posedge hclk);
        payload <= 1'b0;
        tmo <= 1'b0;
    endtask : pulse_end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        trim_wait();
        bus(1'b0, LDC_OFS_LISTEN, 32'h0);
        `CHK("listen_rst", LDC_RST_LISTEN, rd)
        bus(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b1, LDC_OFS_OSC, 32'h1);
        trim_wait();
        bus(1'b1, LDC_OFS_LISTEN, 32'h0002_0154);
        bus(1'b1, LDC_OFS_OPMODE, 32'h41);
        wait_rx(1'b1);
        wait_rx(1'b0);
        power <= 1'b1;
        wait_rx(1'b1);
        pulse_end(1'b1);
        wait_rx(1'b0);
        power <= 1'b0;
        bus(1'b0, LDC_OFS_STATUS, 32'h0);
        `CHK("resume", 3'h1, rd[5:3])
        wait_rx(1'b1);
        @(posedge hclk);
        `CHK("flushes", 1, flush_cnt)
        bus(1'b1, LDC_OFS_OPMODE, 32'h20);
        bus(1'b1, LDC_OFS_OPMODE, 32'h00);
        bus(1'b0, LDC_OFS_STATUS, 32'h0);
        `CHK("cancel", 6'h00, rd[5:0])
        bus(1'b1, LDC_OFS_LISTEN, 32'h0002_015A);
        power <= 1'b1;
        bus(1'b1, LDC_OFS_OPMODE, 32'h01);
        bus(1'b1, LDC_OFS_OPMODE, 32'h41);
        wait_rx(1'b1);
        wait_rx(1'b0);
        sync <= 1'b1;
        wait_rx(1'b1);
        pulse_end(1'b0);
        wait_rx(1'b0);
        bus(1'b0, LDC_OFS_STATUS, 32'h0);
        `CHK("to_mode", 6'h01, rd[5:0])
        bus(1'b1, LDC_OFS_OPMODE, 32'h01);
        bus(1'b1, LDC_OFS_LISTEN, 32'h0002_0150);
        bus(1'b1, LDC_OFS_OPMODE, 32'h41);
        wait_rx(1'b1);
        repeat (200) @(posedge hclk);
        bus(1'b0, LDC_OFS_STATUS, 32'h0);
        `CHK("hold", 6'h1C, rd[5:0])
        bus(1'b1, LDC_OFS_OPMODE, 32'h21);
        bus(1'b1, LDC_OFS_OPMODE, 32'h01);
        `CHK("rx_off", 1'b0, rx_on)
        power <= 1'b0;
        sync <= 1'b0;
        for (int i = 1; i < 4; i++) begin
            bus(1'b1, LDC_OFS_OPMODE, 32'h01);
            bus(1'b1, LDC_OFS_AUTO, 32'h0000_0320 | 32'(i));
            evt <= 3'(1 << (i - 1));
            @(posedge hclk);
            evt <= 3'h0;
            repeat (4) @(posedge hclk);
            `CHK("transit", LDC_MODE_TX, radio_mode)
            bus(1'b1, LDC_OFS_OPMODE, 32'h02);
            bufd <= 1'b0;
            repeat (4) @(posedge hclk);
            `CHK("leave", LDC_MODE_FS, radio_mode)
            bufd <= 1'b1;
            @(posedge hclk);
        end
        tally_and_finish();
    end
endmodule : ldc_sequencer_tb
